// File: hdl/vpo_regs.svh
// Register offsets, field positions, reset values and limits of the pixel port
`ifndef VPO_REGS_SVH
`define VPO_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define VPO_OFS_CTRL 8'h00
`define VPO_OFS_PAD 8'h04
`define VPO_OFS_DFLT 8'h08
`define VPO_OFS_HSPAN 8'h0C
`define VPO_OFS_HSYNC 8'h10
`define VPO_OFS_VSPAN 8'h14
`define VPO_OFS_VSYNC 8'h18
`define VPO_OFS_PIXEL 8'h1C
`define VPO_OFS_STATUS 8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VPO_CTRL_RUN 0
`define VPO_CTRL_WSE 1
`define VPO_LO_LSB 0
`define VPO_HI_LSB 16
`define VPO_PIX_DEPTH_LSB 8
`define VPO_PIX_TAG_LSB 10
`define VPO_ST_UNDERRUN 0
`define VPO_ST_VBLANK 1
`define VPO_ST_ACTIVE 2
`define VPO_ST_LEVEL_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VPO_RST_CTRL 2'h0
`define VPO_RST_PAD 8'h00
`define VPO_RST_DFLT 8'h00
`define VPO_RST_HACT 12'h27F
`define VPO_RST_HTOT 12'h31F
`define VPO_RST_HSST 12'h28F
`define VPO_RST_HSW 12'h05F
`define VPO_RST_VACT 12'h1DF
`define VPO_RST_VTOT 12'h20C
`define VPO_RST_VSST 12'h1E9
`define VPO_RST_VSW 12'h001

// ----------------------------------------------------------------------
// Timing limits
// ----------------------------------------------------------------------
`define VPO_MAX_SYNC 4096
`define VPO_MAX_DOT_MHZ 25

`endif

// File: hdl/vpo_pkg.sv
// Types shared by the pixel output port modules
package vpo_pkg;

  // Pixel depth of the window a pixel belongs to
  typedef enum logic [1:0] {
    VPO_BPP1,
    VPO_BPP2,
    VPO_BPP4,
    VPO_BPP8
  } vpo_depth_e;

  // One queued pixel: window tag bits, depth and data
  typedef struct packed {
    logic [1:0] window_tag_bits;
    vpo_depth_e depth;
    logic [7:0] pix;
  } vpo_pixel_s;

  typedef logic [11:0] vpo_count_t;

endpackage

// File: hdl/vpo_stream_if.sv
// Valid/ready stream carrier between the pixel port modules
`timescale 1ns/1ps
interface vpo_stream_if #(
  parameter int WIDTH = 12
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface // vpo_stream_if

// File: hdl/vpo_fifo.sv
// Pixel FIFO with parameterised width and depth
`timescale 1ns/1ps
module vpo_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8,
  parameter int LW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  vpo_stream_if.snk fill,
  // Drain side
  vpo_stream_if.src drain,
  // Fill level
  output logic [LW-1:0] level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("vpo_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [LW-1:0] cnt_r;
  wire push = fill.valid && fill.ready;
  wire pop = drain.valid && drain.ready;

  assign fill.ready = (cnt_r != LW'(DEPTH));
  assign drain.valid = (cnt_r != '0);
  assign drain.data = mem[rp_r];
  assign level = cnt_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= fill.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= push ? wp_r + 1'b1 : wp_r;
      rp_r <= pop ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + LW'(push) - LW'(pop);
    end
  end
endmodule // vpo_fifo

// File: hdl/vpo_timing.sv
// Horizontal and vertical raster counters with programmable sync pulses
`timescale 1ns/1ps
module vpo_timing (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire vpo_pkg::vpo_count_t hact,
  input wire vpo_pkg::vpo_count_t htot,
  input wire vpo_pkg::vpo_count_t hs_start,
  input wire vpo_pkg::vpo_count_t hs_wm1,
  input wire vpo_pkg::vpo_count_t vact,
  input wire vpo_pkg::vpo_count_t vtot,
  input wire vpo_pkg::vpo_count_t vs_start,
  input wire vpo_pkg::vpo_count_t vs_wm1,
  // Raster state
  output logic active,
  output logic vblank,
  output logic hs,
  output logic vs
);
  import vpo_pkg::*;

  vpo_count_t hcnt_r;
  vpo_count_t vcnt_r;
  wire line_end = (hcnt_r == htot);
  wire frame_end = line_end && (vcnt_r == vtot);

  // Sync width field holds width minus one, giving 1..4096
  function automatic logic in_pulse(vpo_count_t c, vpo_count_t st,
                                    vpo_count_t wm1);
    vpo_count_t off;
    off = c - st;
    return (c >= st) && (off <= wm1);
  endfunction

  assign vblank = (vcnt_r >= vact);
  assign active = run && (hcnt_r < hact) && !vblank;
  // [RULE3] hsync in clocks
  assign hs = run && in_pulse(hcnt_r, hs_start, hs_wm1);
  // [RULE4] vsync in lines
  assign vs = run && in_pulse(vcnt_r, vs_start, vs_wm1);

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      hcnt_r <= '0;
      vcnt_r <= '0;
    end else begin
      hcnt_r <= line_end ? '0 : hcnt_r + 1'b1;
      vcnt_r <= frame_end ? '0 : (line_end ? vcnt_r + 1'b1 : vcnt_r);
    end
  end
endmodule // vpo_timing

// File: hdl/vpo_top.sv
// Video pixel output port: APB registers, pixel FIFO and output stage
// Function
// [RULE1] One pixel of up to eight bits per video clock on eight lines.
// [RULE2] Pixel and sync path runs on the video clock, not the bus clock.
// [RULE3] Hsync width programmable from 1 to 4096 video clocks.
// [RULE4] Vsync width programmable from 1 to 4096 scan lines.
// [RULE5] System feeds video clock from oscillator or same-rate bus clock.
// [RULE6] One-bit pixels drive line zero.
// [RULE7] Lines without pixel bits carry the programmed pad value.
// [RULE8] Two-bit pixels drive lines one and zero, pad the rest.
// [RULE9] Four-bit pixels drive lines three to zero, pad the rest.
// [RULE10] Eight-bit pixels drive all lines, no padding.
// [RULE11] Depths 1, 2, 4, 8 selectable per pixel, sharing the lines.
// [RULE12] Blanking drives the programmed default value on the lines.
// [RULE13] With tag enable set, visible time shows tag bits on syncs.
// [RULE14] With tag enable clear, syncs stay low in visible time.
// [RULE15] Lines and both syncs update together on one clock edge.
// [RULE16] Pad value applies per line, each its own bit.
`include "vpo_regs.svh"
`timescale 1ns/1ps
module vpo_top #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Display side
  output logic [7:0] pixel_out_lines,
  output logic hsync,
  output logic vsync,
  output logic blank
);
  import vpo_pkg::*;

  localparam int PW = $bits(vpo_pixel_s);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_chk
    $error("vpo_top: FIFO_DEPTH must lie in 2..128");
  end

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [1:0] display_mode_control_r;
  logic [7:0] pad_r;
  logic [7:0] dflt_r;
  vpo_count_t hact_r;
  vpo_count_t htot_r;
  vpo_count_t hsst_r;
  vpo_count_t hsw_r;
  vpo_count_t vact_r;
  vpo_count_t vtot_r;
  vpo_count_t vsst_r;
  vpo_count_t vsw_r;
  logic underrun_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [7:0] pix_r;
  logic hsync_r;
  logic vsync_r;
  logic blank_r;
  logic active;
  logic vblank;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire sel_ctrl = (paddr == `VPO_OFS_CTRL);
  wire sel_pad = (paddr == `VPO_OFS_PAD);
  wire sel_dflt = (paddr == `VPO_OFS_DFLT);
  wire sel_hspan = (paddr == `VPO_OFS_HSPAN);
  wire sel_hsync = (paddr == `VPO_OFS_HSYNC);
  wire sel_vspan = (paddr == `VPO_OFS_VSPAN);
  wire sel_vsync = (paddr == `VPO_OFS_VSYNC);
  wire sel_pixel = (paddr == `VPO_OFS_PIXEL);
  wire sel_status = (paddr == `VPO_OFS_STATUS);
  wire mapped = sel_ctrl || sel_pad || sel_dflt || sel_hspan ||
                sel_hsync || sel_vspan || sel_vsync || sel_pixel ||
                sel_status;

  // --------------------------------------------------------------------
  // Pixel FIFO
  // --------------------------------------------------------------------
  vpo_stream_if #(.WIDTH(PW)) fill_if ();
  vpo_stream_if #(.WIDTH(PW)) drain_if ();
  logic [LW-1:0] level;

  vpo_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH),
    .LW(LW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .fill(fill_if),
    .drain(drain_if),
    .level(level)
  );

  // --------------------------------------------------------------------
  // APB handshake
  // --------------------------------------------------------------------
  // A pixel write is held off while the FIFO is full, so software stalls
  wire pix_wr = sel_pixel && pwrite;
  wire access = psel && penable;
  wire can_answer = access && !pready_r && (!pix_wr || fill_if.ready);
  wire commit = access && pready_r;
  wire wr_commit = commit && pwrite && !pslverr_r;

  assign fill_if.valid = wr_commit && sel_pixel;
  assign fill_if.data = {pwdata[`VPO_PIX_TAG_LSB +: 2],
                         pwdata[`VPO_PIX_DEPTH_LSB +: 2],
                         pwdata[7:0]};

  wire [31:0] rd_mux =
    sel_ctrl ? {30'h0, display_mode_control_r} :
    sel_pad ? {24'h0, pad_r} :
    sel_dflt ? {24'h0, dflt_r} :
    sel_hspan ? {4'h0, htot_r, 4'h0, hact_r} :
    sel_hsync ? {4'h0, hsw_r, 4'h0, hsst_r} :
    sel_vspan ? {4'h0, vtot_r, 4'h0, vact_r} :
    sel_vsync ? {4'h0, vsw_r, 4'h0, vsst_r} :
    sel_status ? status_word(level, underrun_r, vblank, active) :
    32'h0;

  function automatic logic [31:0] status_word(logic [LW-1:0] lvl,
                                              logic urun, logic vb,
                                              logic act);
    logic [31:0] w;
    w = 32'h0;
    w[`VPO_ST_UNDERRUN] = urun;
    w[`VPO_ST_VBLANK] = vb;
    w[`VPO_ST_ACTIVE] = act;
    w[`VPO_ST_LEVEL_LSB +: LW] = lvl;
    return w;
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= can_answer;
      pslverr_r <= can_answer && !mapped;
      prdata_r <= (can_answer && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      display_mode_control_r <= `VPO_RST_CTRL;
      pad_r <= `VPO_RST_PAD;
      dflt_r <= `VPO_RST_DFLT;
      hact_r <= `VPO_RST_HACT;
      htot_r <= `VPO_RST_HTOT;
      hsst_r <= `VPO_RST_HSST;
      hsw_r <= `VPO_RST_HSW;
      vact_r <= `VPO_RST_VACT;
      vtot_r <= `VPO_RST_VTOT;
      vsst_r <= `VPO_RST_VSST;
      vsw_r <= `VPO_RST_VSW;
    end else if (wr_commit) begin
      if (sel_ctrl) begin
        display_mode_control_r <= pwdata[1:0];
      end else if (sel_pad) begin
        pad_r <= pwdata[7:0];
      end else if (sel_dflt) begin
        dflt_r <= pwdata[7:0];
      end else if (sel_hspan) begin
        hact_r <= pwdata[`VPO_LO_LSB +: 12];
        htot_r <= pwdata[`VPO_HI_LSB +: 12];
      end else if (sel_hsync) begin
        hsst_r <= pwdata[`VPO_LO_LSB +: 12];
        hsw_r <= pwdata[`VPO_HI_LSB +: 12];
      end else if (sel_vspan) begin
        vact_r <= pwdata[`VPO_LO_LSB +: 12];
        vtot_r <= pwdata[`VPO_HI_LSB +: 12];
      end else if (sel_vsync) begin
        vsst_r <= pwdata[`VPO_LO_LSB +: 12];
        vsw_r <= pwdata[`VPO_HI_LSB +: 12];
      end
    end
  end

  // --------------------------------------------------------------------
  // Raster timing
  // --------------------------------------------------------------------
  wire run = display_mode_control_r[`VPO_CTRL_RUN];
  wire wse = display_mode_control_r[`VPO_CTRL_WSE];
  logic hs;
  logic vs;

  // [RULE2] raster on video clock
  vpo_timing u_timing (
    .clk(clk),
    .rst(rst),
    .run(run),
    .hact(hact_r),
    .htot(htot_r),
    .hs_start(hsst_r),
    .hs_wm1(hsw_r),
    .vact(vact_r),
    .vtot(vtot_r),
    .vs_start(vsst_r),
    .vs_wm1(vsw_r),
    .active(active),
    .vblank(vblank),
    .hs(hs),
    .vs(vs)
  );

  // --------------------------------------------------------------------
  // Pixel formatting
  // --------------------------------------------------------------------
  // One pixel leaves the FIFO per visible clock
  assign drain_if.ready = active;
  vpo_pixel_s cur;
  assign cur = vpo_pixel_s'(drain_if.data);
  wire starved = active && !drain_if.valid;

  // [RULE11] per-pixel depth mask
  function automatic logic [7:0] depth_mask(vpo_depth_e d);
    logic [7:0] m;
    m = 8'hFF;
    case (d)
      VPO_BPP1: m = 8'h01;
      VPO_BPP2: m = 8'h03;
      VPO_BPP4: m = 8'h0F;
      VPO_BPP8: m = 8'hFF;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction

  // [RULE6] [RULE8] [RULE9] [RULE10] low lines carry pixel bits
  wire [7:0] pix_mask = depth_mask(cur.depth);
  // [RULE7] [RULE16] pad each unused line bit by bit
  wire [7:0] pix_fmt = (cur.pix & pix_mask) | (pad_r & ~pix_mask);
  // An empty FIFO shows the pad value rather than stale data
  // [RULE12] blanking shows the default value
  wire [7:0] line_nxt = !active ? dflt_r : (starved ? pad_r : pix_fmt);
  wire [1:0] tag = drain_if.valid ? cur.window_tag_bits : 2'h0;
  // [RULE13] [RULE14] tags or low on syncs in visible time
  wire hsync_nxt = active ? (wse && tag[0]) : hs;
  wire vsync_nxt = active ? (wse && tag[1]) : vs;

  // [RULE1] [RULE15] all display outputs on one edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pix_r <= 8'h00;
      hsync_r <= 1'b0;
      vsync_r <= 1'b0;
      blank_r <= 1'b1;
    end else begin
      pix_r <= line_nxt;
      hsync_r <= hsync_nxt;
      vsync_r <= vsync_nxt;
      blank_r <= !active;
    end
  end

  // --------------------------------------------------------------------
  // Underrun flag
  // --------------------------------------------------------------------
  // Write one to clear; a new underrun in the same cycle wins
  wire urun_clr = wr_commit && sel_status && pwdata[`VPO_ST_UNDERRUN];
  always_ff @(posedge clk) begin
    if (rst) begin
      underrun_r <= 1'b0;
    end else begin
      underrun_r <= starved || (underrun_r && !urun_clr);
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pixel_out_lines = pix_r;
  assign hsync = hsync_r;
  assign vsync = vsync_r;
  assign blank = blank_r;

endmodule // vpo_top

// File: test/vpo_top_asserts.sv
// Port-level assertions for the video pixel output port
`include "vpo_regs.svh"
`timescale 1ns/1ps
module vpo_top_asserts #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Display side
  input wire logic [7:0] pixel_out_lines,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic blank
);
  // ----------------------------------------------------------------------
  // Shadow of the settings that software last wrote
  // ----------------------------------------------------------------------
  logic run_r, tag_r;
  logic [7:0] dflt_r;
  logic [11:0] hsw_r;
  logic [12:0] hs_n_r;
  wire acc = psel && penable && !pready;
  wire done = psel && penable && pready && pwrite && !pslverr;
  wire mapped = paddr[1:0] == 2'h0 && paddr <= `VPO_OFS_STATUS;
  wire hs_b = hsync && blank;
  wire [1:0] ctrl_nxt = (done && paddr == `VPO_OFS_CTRL) ?
    pwdata[1:0] : {tag_r, run_r};
  wire [7:0] dflt_nxt = (done && paddr == `VPO_OFS_DFLT) ?
    pwdata[7:0] : dflt_r;
  wire [11:0] hsw_nxt = (done && paddr == `VPO_OFS_HSYNC) ?
    pwdata[27:16] : hsw_r;
  wire [12:0] hs_n_nxt = hs_b ? hs_n_r + 13'h1 : 13'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      {tag_r, run_r} <= 2'h0;
      dflt_r <= `VPO_RST_DFLT;
      hsw_r <= `VPO_RST_HSW;
      hs_n_r <= 13'h0;
    end else begin
      {tag_r, run_r} <= ctrl_nxt;
      dflt_r <= dflt_nxt;
      hsw_r <= hsw_nxt;
      hs_n_r <= hs_n_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  sequence s_refuse;
    pready && pslverr && prdata == 32'h0;
  endsequence
  a_ready_answer: assert property (
    acc && paddr != `VPO_OFS_PIXEL |=> s_answer)
    else $error("register access not answered in one cycle");
  a_unmapped_err: assert property (
    acc && !mapped |=> s_refuse)
    else $error("unmapped access not refused");
  a_rdata_idle: assert property (
    !pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside answer");
  a_pixel_wo: assert property (
    acc && !pwrite && paddr == `VPO_OFS_PIXEL |=> prdata == 32'h0)
    else $error("pixel register read not zero");
  a_blank_default: assert property (
    blank && $stable(dflt_r) && dflt_r == $past(dflt_r, 2)
    |-> pixel_out_lines == dflt_r)
    else $error("blank lines not default value");
  a_visible_quiet: assert property (
    !blank && !tag_r && !$past(tag_r) && !$past(tag_r, 2)
    |-> !hsync && !vsync)
    else $error("sync high in visible time");
  a_idle_blank: assert property (
    !run_r [*3] |-> blank && !hsync && !vsync)
    else $error("stopped raster not blank");
  a_hsync_width: assert property (
    $fell(hs_b) && run_r |-> hs_n_r == {1'b0, hsw_r} + 13'h1)
    else $error("hsync width wrong");
endmodule // vpo_top_asserts

bind vpo_top vpo_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_asserts (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pixel_out_lines(pixel_out_lines),
  .hsync(hsync), .vsync(vsync), .blank(blank));

// File: test/vpo_display_model.sv
// Display monitor that records the visible pixels and sync widths
`timescale 1ns/1ps
module vpo_display_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Display side
  input wire logic [7:0] pixel_out_lines,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic blank
);
  logic [9:0] seen[$];
  int hs_n, vs_n, hs_w, vs_w, frames;
  // lines and syncs taken on one edge
  always @(posedge clk) begin
    if (rst) begin
      hs_n = 0;
      vs_n = 0;
      frames = 0;
    end else begin
      // tags only mean something in visible time
      if (!blank) seen.push_back({vsync, hsync, pixel_out_lines});
      // Syncs are only pulses while blank, tags aside
      if (hsync && blank) hs_n++;
      else if (hs_n > 0) begin
        hs_w = hs_n;
        hs_n = 0;
      end
      if (vsync && blank) vs_n++;
      else if (vs_n > 0) begin
        vs_w = vs_n;
        vs_n = 0;
        frames++;
      end
    end
  end
endmodule // vpo_display_model

// File: test/tb.sv
// Self-checking bench for the video pixel output port
`include "vpo_regs.svh"
`timescale 1ns/1ps
module tb;
  import vpo_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic hsync, vsync, blank, err;
  logic [7:0] paddr, pixel_out_lines, pad;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] px;
  logic [9:0] exp_q[$];
  int mismatches, comparisons, w, f, n;
  vpo_top #(.FIFO_DEPTH(8)) uut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_out_lines(pixel_out_lines), .hsync(hsync), .vsync(vsync),
    .blank(blank));
  vpo_display_model mon (.clk(clk), .rst(rst),
    .pixel_out_lines(pixel_out_lines), .hsync(hsync), .vsync(vsync),
    .blank(blank));
  // one oscillator serves as bus and dot clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] shape(logic [7:0] p, logic [1:0] d,
    logic [7:0] pd);
    case (d)
      2'h0: return {pd[7:1], p[0]};
      2'h1: return {pd[7:2], p[1:0]};
      2'h2: return {pd[7:4], p[3:0]};
      default: return p;
    endcase
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Held until pready is sampled; never times out silently
  task automatic rw(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 500);
    rd = prdata;
    err = pslverr;
    if (k >= 500) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    give_verdict();
  end
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
    mismatches = 0;
    comparisons = 0;
    void'($urandom(21));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rw(0, `VPO_OFS_HSPAN, 0);
    cmp(rd, {4'h0, `VPO_RST_HTOT, 4'h0, `VPO_RST_HACT});
    rw(0, `VPO_OFS_VSYNC, 0);
    cmp(rd, {4'h0, `VPO_RST_VSW, 4'h0, `VPO_RST_VSST});
    rw(0, 8'h24, 0);
    cmp({31'h0, err}, 32'h1);
    rw(0, `VPO_OFS_PIXEL, 0);
    cmp(rd, 32'h0);
    $display("test registers done");
    for (int r = 0; r < 2; r++) begin
      w = (r == 0) ? 0 : $urandom_range(3, 1);
      pad = 8'($urandom);
      rw(1, `VPO_OFS_CTRL, 0);
      rw(1, `VPO_OFS_PAD, {24'h0, pad});
      rw(1, `VPO_OFS_DFLT, $urandom);
      rw(1, `VPO_OFS_HSPAN, {4'h0, 12'(12 + w), 4'h0, 12'h007});
      rw(1, `VPO_OFS_HSYNC, {4'h0, 12'(w), 4'h0, 12'h009});
      rw(1, `VPO_OFS_VSPAN, {4'h0, 12'(4 + r), 4'h0, 12'h002});
      rw(1, `VPO_OFS_VSYNC, {4'h0, 12'(r), 4'h0, 12'h003});
      mon.seen.delete();
      exp_q.delete();
      // Every depth code appears twice per frame
      for (int i = 0; i < 8; i++) begin
        px = 12'($urandom);
        px[9:8] = i[1:0];
        exp_q.push_back({(r == 0) ? px[11:10] : 2'h0,
          shape(px[7:0], px[9:8], pad)});
        rw(1, `VPO_OFS_PIXEL, {20'h0, px});
      end
      exp_q.push_back({2'h0, pad});
      rw(0, `VPO_OFS_STATUS, 0);
      cmp({28'h0, rd[11:8]}, 32'h8);
      f = mon.frames;
      rw(1, `VPO_OFS_CTRL, {30'h0, r == 0, 1'b1});
      n = 0;
      while (mon.frames == f && n < 1000) begin
        @(posedge clk);
        n++;
      end
      // A frame that never ends is a failure, not a silent skip
      if (n >= 1000) mismatches++;
      for (int i = 0; i < 9; i++) begin
        cmp({22'h0, mon.seen[i]}, {22'h0, exp_q[i]});
      end
      cmp(32'(mon.hs_w), 32'(w + 1));
      cmp(32'(mon.vs_w), 32'((r + 1) * (13 + w)));
      $display("test frame %0d done", r);
    end
    rw(1, `VPO_OFS_CTRL, 0);
    // Visible clocks ran past the eight queued pixels, so underrun is set
    rw(0, `VPO_OFS_STATUS, 0);
    cmp({31'h0, rd[0]}, 32'h1);
    rw(1, `VPO_OFS_STATUS, 32'h1);
    rw(0, `VPO_OFS_STATUS, 0);
    cmp({31'h0, rd[0]}, 32'h0);
    $display("test status done");
    give_verdict();
  end
endmodule // tb
